// file: design/apmc_ctrl_reg.sv
// Control register captured on the write strobe rising edge
`timescale 1ns/1ns
`include "apmc_regs.svh"
module apmc_ctrl_reg
    import apmc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Host write side
    input  wire logic                   wr_rise,
    input  wire logic [`APMC_CTRL_W-1:0] wr_data,
    // Stored value
    output logic      [`APMC_CTRL_W-1:0] ctrl_r
);
    // Only a write strobe changes the word, so shutdown keeps it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `APMC_CTRL_RESET;
        end else if (wr_rise) begin
            ctrl_r <= wr_data;
        end
    end
endmodule : apmc_ctrl_reg

// file: design/apmc_pkg.sv
// Types of the converter power-mode controller
package apmc_pkg;
    typedef enum logic [1:0] {
        APMC_NORMAL    = 2'h0,
        APMC_AUTO_SHDN = 2'h1,
        APMC_AUTO_STBY = 2'h2,
        APMC_FULL_SHDN = 2'h3
    } apmc_mode_type;

    typedef struct packed {
        logic powered;
        logic ref_on;
        logic track;
        logic ready;
        logic invalid;
    } apmc_stat_type;
endpackage : apmc_pkg

// file: design/apmc_regs.svh
// Constants and operating summary of the converter power-mode controller
// Overview of operation
// - Power field both bits set selects full shutdown until the field changes.
// - Writing full shutdown powers everything down at the write strobe rising edge.
// - Full shutdown puts track-and-hold in hold for its whole duration.
// - Control register contents are kept unchanged through full shutdown.
// - Full shutdown ends only when a write changes the power field.
// - Writing normal mode during shutdown starts power-up and returns to track.
// - Automatic modes power up at the convert start rising edge and power down when a conversion ends.
// - Field codes: 00 normal, 01 auto shutdown, 10 auto standby.
// - Power-on reset selects normal mode.
// - Write data is captured on the rising edge of the low write strobe.
`ifndef APMC_REGS_SVH
`define APMC_REGS_SVH
`define APMC_CTRL_W        12
`define APMC_PM_LO_POS     4
`define APMC_PM_HI_POS     5
`define APMC_CTRL_RESET    12'h000
`define APMC_CLK_HZ        10000000
`define APMC_SHDN_UP_NS    10000000
`define APMC_STBY_UP_NS    600
`define APMC_CONV_CYC      16'h000F
`define APMC_CYC(ns)       ((((ns) * 64'd10) + 64'd999) / 64'd1000)
`define APMC_STBY_CYC      16'(`APMC_CYC(`APMC_STBY_UP_NS))
`define APMC_SHDN_CYC      `APMC_CYC(`APMC_SHDN_UP_NS)
`endif

// file: design/apmc_top.sv
// Power-mode sequencing of the converter: shutdown, standby, power-up waits
`timescale 1ns/1ns
`include "apmc_regs.svh"
module apmc_top
    import apmc_pkg::*;
#(
    parameter logic [31:0] SHDN_UP_CYC = 32'(`APMC_SHDN_CYC)
)(
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    // Host parallel bus
    input  wire logic                    CS_N,
    input  wire logic                    WR_N,
    input  wire logic [`APMC_CTRL_W-1:0] DATA_IN,
    input  wire logic                    CONVERT_START_N,
    // Power and status
    output logic                         POWERED,
    output logic                         REF_ON,
    output logic                         TRACK,
    output logic                         READY,
    output logic                         CONV_INVALID,
    output logic                         BUSY,
    output logic [`APMC_CTRL_W-1:0]      CTRL_OUT
);
    ////////////////////////////////////////////////////////////////
    logic                    wr_act_r;
    logic                    cv_r;
    logic [`APMC_CTRL_W-1:0] ctrl_r;
    logic [31:0]             up_cnt_r;
    logic [15:0]             conv_cnt_r;
    logic                    pwr_r;
    logic                    ref_r;
    logic                    trk_r;
    logic                    bad_r;
    apmc_stat_type           st_r;

    wire wr_act   = !CS_N && !WR_N;
    wire wr_rise  = wr_act_r && !wr_act;
    wire cv_fall  = cv_r && !CONVERT_START_N;
    wire cv_rise  = !cv_r && CONVERT_START_N;
    wire [1:0] pm = ctrl_r[`APMC_PM_HI_POS:`APMC_PM_LO_POS];
    wire [1:0] pm_new = DATA_IN[`APMC_PM_HI_POS:`APMC_PM_LO_POS];
    wire full_shdn = (pm == APMC_FULL_SHDN);
    wire wr_shdn   = wr_rise && (pm_new == APMC_FULL_SHDN);
    wire wr_wake   = wr_rise && (pm_new != APMC_FULL_SHDN) && full_shdn;
    wire conv_busy = (conv_cnt_r != 16'h0000);
    wire conv_done = (conv_cnt_r == 16'h0001);
    wire auto_mode = (pm == APMC_AUTO_SHDN) || (pm == APMC_AUTO_STBY);
    wire up_done   = (up_cnt_r == 32'h0);
    wire auto_wake = cv_rise && auto_mode && !pwr_r;
    wire [31:0] wake_cyc = (pm == APMC_AUTO_STBY) ? 32'(`APMC_STBY_CYC) : SHDN_UP_CYC;

    apmc_ctrl_reg u_ctrl (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_rise (wr_rise),
        .wr_data (DATA_IN),
        .ctrl_r  (ctrl_r)
    );

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_act_r <= 1'b0;
            cv_r     <= 1'b1;
        end else begin
            wr_act_r <= wr_act;
            cv_r     <= CONVERT_START_N;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            conv_cnt_r <= 16'h0000;
        end else if (cv_fall && pwr_r) begin
            conv_cnt_r <= `APMC_CONV_CYC;
        end else if (conv_busy) begin
            conv_cnt_r <= conv_cnt_r - 16'h0001;
        end
    end

    // Power, reference and track state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pwr_r    <= 1'b1;
            ref_r    <= 1'b1;
            trk_r    <= 1'b0;
            up_cnt_r <= 32'h0;
        end else if (wr_shdn) begin
            pwr_r    <= 1'b0;
            ref_r    <= 1'b0;
            trk_r    <= 1'b0;
            up_cnt_r <= 32'h0;
        end else if (wr_wake) begin
            pwr_r    <= 1'b1;
            ref_r    <= 1'b1;
            trk_r    <= 1'b1;
            up_cnt_r <= SHDN_UP_CYC;
        end else if (conv_done && auto_mode) begin
            pwr_r    <= 1'b0;
            ref_r    <= (pm == APMC_AUTO_STBY);
            trk_r    <= 1'b0;
        end else if (auto_wake) begin
            pwr_r    <= 1'b1;
            ref_r    <= 1'b1;
            trk_r    <= 1'b1;
            up_cnt_r <= wake_cyc;
        end else begin
            if (cv_rise && pwr_r && !full_shdn) begin
                trk_r <= 1'b1;
            end
            if (!up_done) begin
                up_cnt_r <= up_cnt_r - 32'h1;
            end
        end
    end

    // Early conversion start marks result invalid
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bad_r <= 1'b0;
        end else if (cv_fall) begin
            bad_r <= !pwr_r || !up_done;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= '{powered: pwr_r, ref_on: ref_r, track: trk_r,
                      ready: pwr_r && up_done, invalid: bad_r};
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            POWERED      <= 1'b0;
            REF_ON       <= 1'b0;
            TRACK        <= 1'b0;
            READY        <= 1'b0;
            CONV_INVALID <= 1'b0;
            BUSY         <= 1'b0;
            CTRL_OUT     <= `APMC_CTRL_RESET;
        end else begin
            POWERED      <= st_r.powered;
            REF_ON       <= st_r.ref_on;
            TRACK        <= st_r.track;
            READY        <= st_r.ready;
            CONV_INVALID <= st_r.invalid;
            BUSY         <= conv_busy;
            CTRL_OUT     <= ctrl_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_shdn_off;
        @(posedge CLK) disable iff (!RST_N)
        wr_shdn |=> !pwr_r && !trk_r;
    endproperty
    a_shdn_off: assert property (p_shdn_off) else $error("shutdown write left power on");

    property p_hold_in_shdn;
        @(posedge CLK) disable iff (!RST_N)
        full_shdn && !wr_rise |=> !trk_r;
    endproperty
    a_hold_in_shdn: assert property (p_hold_in_shdn) else $error("track during shutdown");

    property p_keep_ctrl;
        @(posedge CLK) disable iff (!RST_N)
        !wr_rise |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_keep_ctrl: assert property (p_keep_ctrl) else $error("control word changed");

    property p_stay_shdn;
        @(posedge CLK) disable iff (!RST_N)
        full_shdn && !wr_rise |=> full_shdn && !pwr_r;
    endproperty
    a_stay_shdn: assert property (p_stay_shdn) else $error("left shutdown without write");

    sequence s_wake;
        wr_wake ##1 pwr_r && trk_r;
    endsequence
    property p_wake;
        @(posedge CLK) disable iff (!RST_N)
        wr_wake |-> s_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("normal write did not power up");

    property p_capture;
        @(posedge CLK) disable iff (!RST_N)
        wr_rise |=> ctrl_r == $past(DATA_IN);
    endproperty
    a_capture: assert property (p_capture) else $error("write data not captured");

    property p_out_ctrl;
        @(posedge CLK) disable iff (!RST_N)
        wr_rise |=> ##1 CTRL_OUT == $past(DATA_IN, 2);
    endproperty
    a_out_ctrl: assert property (p_out_ctrl) else $error("control output stale");

    property p_early;
        @(posedge CLK) disable iff (!RST_N)
        cv_fall && !up_done |-> ##3 CONV_INVALID;
    endproperty
    a_early: assert property (p_early) else $error("early start not flagged");

    property p_auto_down;
        @(posedge CLK) disable iff (!RST_N)
        conv_done && auto_mode && !wr_rise |=> !pwr_r;
    endproperty
    a_auto_down: assert property (p_auto_down) else $error("auto mode stayed powered");

    // Wake must also restart the power-up wait, or early starts go unflagged
    property p_auto_wake;
        @(posedge CLK) disable iff (!RST_N)
        auto_wake |=> pwr_r && trk_r && !up_done;
    endproperty
    a_auto_wake: assert property (p_auto_wake) else $error("auto mode did not wake");

    property p_stby_ref;
        @(posedge CLK) disable iff (!RST_N)
        conv_done && (pm == APMC_AUTO_STBY) && !wr_rise |=> ref_r;
    endproperty
    a_stby_ref: assert property (p_stby_ref) else $error("standby lost reference");
endmodule : apmc_top

// file: verif/apmc_host.sv
// Host processor model: parallel control writes and conversion starts
`timescale 1ns/1ns
module apmc_host
    import apmc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Parallel bus towards the converter
    output logic             cs_n,
    output logic             wr_n,
    output logic [11:0]      data,
    output logic             conv_n
);
    initial begin
        cs_n   = 1'b1;
        wr_n   = 1'b1;
        data   = 12'hFFF;
        conv_n = 1'b1;
    end

    // One word-mode write; data held through the edge that takes it
    task automatic wr(input logic [11:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        data <= d;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        // Strobe rise is seen one edge late, so data must still stand there
        @(posedge clk);
        data <= ~d;
    endtask : wr

    // Caller owns the power-up wait before this falling edge
    task automatic start();
        @(posedge clk);
        conv_n <= 1'b0;
    endtask : start

    task automatic rise();
        @(posedge clk);
        conv_n <= 1'b1;
    endtask : rise
endmodule : apmc_host

// file: verif/test_adc_power_mode_control.sv
// Self-checking bench of the converter power-mode controller
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module test_adc_power_mode_control
    import apmc_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        cs_n, wr_n, conv_n;
    logic [11:0] data, ctrl;
    logic        pwr, ref_on, trk, rdy, inval, busy;
    int          n_errors;
    int          n_tests;

    apmc_top #(.SHDN_UP_CYC(32'h14)) u_dut (
        .CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .WR_N(wr_n), .DATA_IN(data),
        .CONVERT_START_N(conv_n), .POWERED(pwr), .REF_ON(ref_on), .TRACK(trk),
        .READY(rdy), .CONV_INVALID(inval), .BUSY(busy), .CTRL_OUT(ctrl)
    );
    apmc_host u_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .data(data), .conv_n(conv_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Conversion with a fixed 15-cycle busy window
    task automatic conv(input logic bad);
        u_host.start();
        cyc(4);
        `CHK("busy", 1'b1, busy)
        `CHK("invalid", bad, inval)
        cyc(16);
        `CHK("busy end", 1'b0, busy)
    endtask : conv

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cyc(2);
        `CHK("ctrl", 12'h000, ctrl)
        `CHK("powered", 1'b1, pwr)
        `CHK("ready", 1'b1, rdy)
        `CHK("track", 1'b0, trk)
    endtask : t_reset

    task automatic t_full_shutdown();
        u_host.wr(12'h030);
        cyc(5);
        `CHK("powered", 1'b0, pwr)
        `CHK("ref", 1'b0, ref_on)
        `CHK("track", 1'b0, trk)
        `CHK("ctrl", 12'h030, ctrl)
        u_host.start();
        cyc(5);
        `CHK("busy off", 1'b0, busy)
        `CHK("invalid", 1'b1, inval)
        u_host.rise();
        cyc(3);
        `CHK("hold", 1'b0, trk)
        u_host.wr(12'h0F3);
        cyc(30);
        `CHK("powered", 1'b0, pwr)
        `CHK("track", 1'b0, trk)
        `CHK("ctrl", 12'h0F3, ctrl)
    endtask : t_full_shutdown

    task automatic t_wake();
        u_host.wr(12'h0C3);
        cyc(4);
        `CHK("powered", 1'b1, pwr)
        `CHK("track", 1'b1, trk)
        `CHK("ready", 1'b0, rdy)
        `CHK("ctrl", 12'h0C3, ctrl)
        conv(1'b1);
        u_host.rise();
        cyc(25);
        `CHK("ready", 1'b1, rdy)
        conv(1'b0);
        u_host.rise();
    endtask : t_wake

    task automatic t_auto(input logic [11:0] d, input logic ref_kept, input int wake);
        u_host.wr(d);
        cyc(4);
        `CHK("powered", 1'b1, pwr)
        conv(1'b0);
        cyc(2);
        `CHK("auto off", 1'b0, pwr)
        `CHK("auto ref", ref_kept, ref_on)
        `CHK("auto hold", 1'b0, trk)
        u_host.rise();
        cyc(wake);
        `CHK("awake", 1'b1, pwr)
        `CHK("ready", 1'b1, rdy)
        `CHK("track", 1'b1, trk)
    endtask : t_auto

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors = 0;
        n_tests  = 0;
        rst_n    = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_full_shutdown();
        t_wake();
        t_auto(12'h020, 1'b1, 9);
        t_auto(12'h010, 1'b0, 25);
        end_of_test();
    end

    // Whole run is under 400 cycles; four times that is a hang
    initial begin
        #160000;
        n_errors++;
        end_of_test();
    end
endmodule : test_adc_power_mode_control
